/* rgbp_core.sv */
// Purpose: Serial frame receiver, internal latch and grayscale PWM engine.
// Assumes: Link pins are synchronous to ref_clk; ref_clk is the oscillator.
// Notes: Analog sinks and edge shaping sit outside; fast_edge steers them.
//
// Functional notes
// R01: Command word is frame bits 207:192.
// R02: Command bit 10 selects fast output edges.
// R03: Bits 9:8 pick 8/12/14/16-bit depth.
// R04: Bits 7:5 divide oscillator 1 to 256.
// R05: Bit 4 picks legacy or adaptive waveform.
// R06: Bit 3 picks internal or external clock.
// R07: Bit 2 inverts outputs for generator use.
// R08: Bit 1 selects counter-restart frames.
// R09: Bit 0 selects single-frame operation; the core also needs bit 1 set.
// R10: Channel values descend from bits 191:176.
// R11: Host right-aligns short values, zero-filled.
// R12: Clock idle over 220 us starts latch.
// R13: Host sends four data pulses after idle.
// R14: Latch on second data falling edge.
// R15: Host keeps stop interval cascade-safe.
// R16: Forwarded latch pulses regenerated 90 ns wide; the core gives 3 cycles, 75 ns.
// R17: External clock advances counter both edges.
// R18: Output on while value exceeds counter.
// R19: Free-running frames finish before new data.
// R20: Restart mode aborts frame on latch.
// R21: Single-frame mode runs once then off.
// R22: Adaptive mode uses more segments above 75%.
// R23: Idle counter reset by clock edges.
`timescale 1ns/1ps
`default_nettype none
module rgbp_core #(
	parameter int IDLE_CYCLES = rgbp_pkg::IDLE_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial link in
	input wire logic serial_data_in,
	input wire logic serial_clock_in,
	input wire logic ext_gray_clock_pin,
	// Serial link out
	output logic serial_data_out,
	output logic serial_clock_out,
	// Channel drive
	output logic [rgbp_pkg::NCH-1:0] ch_out,
	output logic fast_edge,
	// Status
	output logic gray_latch_strobe,
	output logic frame_active
);
	localparam logic [rgbp_pkg::IDLE_CNT_W-1:0] IDLE_TOP =
		rgbp_pkg::IDLE_CNT_W'(IDLE_CYCLES);

	// ----------------------------------------
	// Link receiver state
	// ----------------------------------------
	rgbp_pkg::rgbp_link_st_t state, next_state;
	logic sck_q, next_sck_q, sdi_q, next_sdi_q;
	logic [rgbp_pkg::IDLE_CNT_W-1:0] idle_cnt, next_idle_cnt;
	logic [2:0] fall_cnt, next_fall_cnt;
	logic [rgbp_pkg::BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
	logic [rgbp_pkg::GS_W-1:0] shift, next_shift, word, next_word;
	logic wvalid, next_wvalid, latch_req, next_latch_req;
	logic copy, next_copy;
	logic [rgbp_pkg::RT_CNT_W-1:0] rt_cnt, next_rt_cnt;
	logic next_sdo, next_sco;
	logic [rgbp_pkg::GS_W-1:0] staging [rgbp_pkg::NWORD];
	logic [rgbp_pkg::GS_W-1:0] next_staging [rgbp_pkg::NWORD];
	logic sck_edge, sck_rise, sdi_rise, sdi_fall;
	logic push_ready, pop_valid, drain_ready;
	logic [rgbp_pkg::GS_W-1:0] pop_data;

	assign sck_edge = serial_clock_in ^ sck_q;
	assign sck_rise = serial_clock_in & ~sck_q;
	assign sdi_rise = serial_data_in & ~sdi_q;
	assign sdi_fall = ~serial_data_in & sdi_q;
	// The frame stage holds still while it is being copied out.
	assign drain_ready = ~copy;

	rgbp_fifo #(
		.WIDTH(rgbp_pkg::GS_W),
		.DEPTH(rgbp_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(wvalid),
		.in_ready(push_ready),
		.in_data(word),
		.out_valid(pop_valid),
		.out_ready(drain_ready),
		.out_data(pop_data)
	);

	always_comb begin
		next_sck_q = serial_clock_in;
		next_sdi_q = serial_data_in;
		next_state = state;
		next_idle_cnt = idle_cnt;
		next_fall_cnt = fall_cnt;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_word = word;
		next_wvalid = wvalid & ~push_ready;
		next_latch_req = latch_req;
		next_copy = 1'b0;
		next_rt_cnt = rt_cnt;
		next_sco = serial_clock_in;
		next_sdo = serial_data_in;
		for (int i = 0; i < rgbp_pkg::NWORD; i++) begin
			next_staging[i] = staging[i];
		end
		// R23: idle counter restart
		if (sck_edge) begin
			next_idle_cnt = '0;
			next_state = rgbp_pkg::ST_SHIFT;
			next_fall_cnt = '0;
		end else if (idle_cnt != IDLE_TOP) begin
			next_idle_cnt = idle_cnt + 1'b1;
		end
		// R01: frame shifts in MSB first
		if (sck_rise) begin
			next_shift = {shift[rgbp_pkg::GS_W-2:0], serial_data_in};
			next_bit_cnt = bit_cnt + 1'b1;
			if (bit_cnt == rgbp_pkg::LAST_BIT) begin
				next_word = next_shift;
				next_wvalid = 1'b1;
			end
		end
		if (rt_cnt != '0) begin
			next_rt_cnt = rt_cnt - 1'b1;
		end
		unique case (state)
			rgbp_pkg::ST_SHIFT: begin
				// R12: idle period detected
				if (!sck_edge && idle_cnt == IDLE_TOP) begin
					next_state = rgbp_pkg::ST_ARMED;
					next_bit_cnt = '0;
				end
			end
			rgbp_pkg::ST_ARMED: begin
				// R16: regenerate forwarded pulse
				next_sdo = (next_rt_cnt != '0);
				if (sdi_rise) begin
					next_rt_cnt = rgbp_pkg::RT_CNT_W'(rgbp_pkg::RETIME_CYC);
					next_sdo = 1'b1;
				end
				if (sdi_fall && !sck_edge) begin
					next_fall_cnt = fall_cnt + 1'b1;
					// R14: second falling edge latches
					if (next_fall_cnt == rgbp_pkg::LATCH_FALL) begin
						next_latch_req = 1'b1;
					end
					if (next_fall_cnt == rgbp_pkg::SEQ_PULSES) begin
						next_state = rgbp_pkg::ST_DONE;
					end
				end
			end
			rgbp_pkg::ST_DONE: begin
				next_sdo = (next_rt_cnt != '0);
			end
		endcase
		// Copy only once every received word has reached the frame stage.
		if (latch_req && !pop_valid && !wvalid) begin
			next_copy = 1'b1;
			next_latch_req = 1'b0;
		end
		if (pop_valid && drain_ready) begin
			for (int i = rgbp_pkg::NWORD - 1; i > 0; i--) begin
				next_staging[i] = staging[i-1];
			end
			next_staging[0] = pop_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= rgbp_pkg::ST_SHIFT;
			sck_q <= 1'b0;
			sdi_q <= 1'b0;
			idle_cnt <= '0;
			fall_cnt <= '0;
			bit_cnt <= '0;
			shift <= '0;
			word <= '0;
			wvalid <= 1'b0;
			latch_req <= 1'b0;
			copy <= 1'b0;
			rt_cnt <= '0;
			serial_data_out <= 1'b0;
			serial_clock_out <= 1'b0;
			for (int i = 0; i < rgbp_pkg::NWORD; i++) begin
				staging[i] <= '0;
			end
		end else begin
			state <= next_state;
			sck_q <= next_sck_q;
			sdi_q <= next_sdi_q;
			idle_cnt <= next_idle_cnt;
			fall_cnt <= next_fall_cnt;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			word <= next_word;
			wvalid <= next_wvalid;
			latch_req <= next_latch_req;
			copy <= next_copy;
			rt_cnt <= next_rt_cnt;
			serial_data_out <= next_sdo;
			serial_clock_out <= next_sco;
			for (int i = 0; i < rgbp_pkg::NWORD; i++) begin
				staging[i] <= next_staging[i];
			end
		end
	end

	// ----------------------------------------
	// Grayscale engine
	// ----------------------------------------
	rgbp_pkg::rgbp_cmd_t cmd, next_cmd;
	logic [rgbp_pkg::GS_W-1:0] shadow [rgbp_pkg::NCH];
	logic [rgbp_pkg::GS_W-1:0] next_shadow [rgbp_pkg::NCH];
	logic [rgbp_pkg::GS_W-1:0] active [rgbp_pkg::NCH];
	logic [rgbp_pkg::GS_W-1:0] next_active [rgbp_pkg::NCH];
	logic [rgbp_pkg::GS_W-1:0] gcnt, next_gcnt;
	logic [7:0] div_cnt, next_div_cnt;
	logic gck_q, next_gck_q, running, next_running;
	logic pending, next_pending;
	logic [rgbp_pkg::NCH-1:0] next_ch;

	always_comb begin
		logic [8:0] div_one;
		logic [7:0] div_mask;
		logic [4:0] depth, seg, sh;
		logic [16:0] full;
		logic [15:0] gmax, scr, low_mask;
		logic [17:0] thr;
		logic tick, all_high, start;
		div_one = 9'h001 << rgbp_pkg::div_log2(cmd.osc_div);
		div_mask = 8'(div_one - 9'h001);
		depth = rgbp_pkg::depth_bits(cmd.grayscale_depth_sel);
		full = 17'h00001 << depth;
		gmax = 16'(full - 17'h00001);
		thr = 18'({gmax, 2'h0} - {2'h0, gmax});
		next_gck_q = ext_gray_clock_pin;
		next_cmd = cmd;
		next_gcnt = gcnt;
		next_running = running;
		next_pending = pending;
		start = 1'b0;
		for (int i = 0; i < rgbp_pkg::NCH; i++) begin
			next_shadow[i] = shadow[i];
			next_active[i] = active[i];
		end
		// R04: oscillator divider
		next_div_cnt = (div_cnt == div_mask) ? 8'h00 : div_cnt + 8'h01;
		// R06: clock source select; R17: both pin edges count
		tick = cmd.ext_clk ? (ext_gray_clock_pin ^ gck_q)
			: (div_cnt == div_mask);
		if (copy) begin
			// R01: command word leads the frame
			next_cmd = rgbp_pkg::rgbp_cmd_t'(staging[rgbp_pkg::CMD_IDX]);
			// R10: channel words follow in order
			for (int i = 0; i < rgbp_pkg::NCH; i++) begin
				next_shadow[i] = staging[rgbp_pkg::CMD_IDX-1-i];
			end
			// R08 R20: restart aborts at once; R19: first latch aligns
			start = next_cmd.restart || !running;
			next_pending = !start;
			next_div_cnt = 8'h00;
		end else if (tick && running) begin
			if (gcnt == gmax) begin
				next_gcnt = '0;
				// R09 R21: single frame then off, only with restart also set
				if (cmd.one_shot && cmd.restart) begin
					next_running = 1'b0;
				end
				// R19: new data waits for frame end
				if (pending) begin
					for (int i = 0; i < rgbp_pkg::NCH; i++) begin
						next_active[i] = shadow[i];
					end
					next_pending = 1'b0;
				end
			end else begin
				next_gcnt = gcnt + 16'h0001;
			end
		end
		if (start) begin
			next_gcnt = '0;
			next_running = 1'b1;
			for (int i = 0; i < rgbp_pkg::NCH; i++) begin
				next_active[i] = next_shadow[i];
			end
		end
		// R22: segment count from all channels
		all_high = 1'b1;
		for (int i = 0; i < rgbp_pkg::NCH; i++) begin
			if ({active[i], 2'h0} < thr) begin
				all_high = 1'b0;
			end
		end
		seg = all_high ? rgbp_pkg::SEG_FINE : rgbp_pkg::SEG_COARSE;
		sh = depth - seg;
		low_mask = 16'((17'h00001 << sh) - 17'h00001);
		// R05: spread on-time across segments, else single pulse
		scr = cmd.adaptive_density_modulation
			? (((gcnt & low_mask) << seg) | (gcnt >> sh)) : gcnt;
		for (int i = 0; i < rgbp_pkg::NCH; i++) begin
			// R18: on while value exceeds counter; R07: polarity
			next_ch[i] = (running && active[i] > scr) ^ cmd.polarity;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmd <= rgbp_pkg::rgbp_cmd_t'(rgbp_pkg::CMD_RESET);
			gcnt <= '0;
			div_cnt <= '0;
			gck_q <= 1'b0;
			running <= 1'b0;
			pending <= 1'b0;
			ch_out <= '0;
			fast_edge <= 1'b0;
			gray_latch_strobe <= 1'b0;
			frame_active <= 1'b0;
			for (int i = 0; i < rgbp_pkg::NCH; i++) begin
				shadow[i] <= '0;
				active[i] <= '0;
			end
		end else begin
			cmd <= next_cmd;
			gcnt <= next_gcnt;
			div_cnt <= next_div_cnt;
			gck_q <= next_gck_q;
			running <= next_running;
			pending <= next_pending;
			ch_out <= next_ch;
			// R02: edge speed to the output stage
			fast_edge <= next_cmd.fast_edge;
			gray_latch_strobe <= copy;
			frame_active <= next_running;
			for (int i = 0; i < rgbp_pkg::NCH; i++) begin
				shadow[i] <= next_shadow[i];
				active[i] <= next_active[i];
			end
		end
	end
endmodule
`default_nettype wire

/* rgbp_core_checker.sv */
// Purpose: Port-level assertions for the grayscale PWM core.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Helper counters track link idle time and data falls.
`timescale 1ns/1ps
`default_nettype none
module rgbp_core_checker #(
	parameter int IDLE_CYCLES = 8800
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial link
	input wire logic serial_data_in,
	input wire logic serial_clock_in,
	input wire logic ext_gray_clock_pin,
	input wire logic serial_data_out,
	input wire logic serial_clock_out,
	// Outputs and status
	input wire logic [rgbp_pkg::NCH-1:0] ch_out,
	input wire logic fast_edge,
	input wire logic gray_latch_strobe,
	input wire logic frame_active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic prev_sck;
	logic prev_sdi;
	logic seen;
	int idle;
	int nfall;
	int fall_age;

	// Falls only count since the last link clock edge, as arming does.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_sck <= 1'b0;
			prev_sdi <= 1'b0;
			seen <= 1'b0;
			idle <= 0;
			nfall <= 0;
			fall_age <= 1000;
		end else begin
			prev_sck <= serial_clock_in;
			prev_sdi <= serial_data_in;
			seen <= seen | gray_latch_strobe;
			if (prev_sdi && !serial_data_in) begin
				fall_age <= 0;
				nfall <= nfall + 1;
			end else if (fall_age < 1000) begin
				fall_age <= fall_age + 1;
			end
			if (serial_clock_in != prev_sck) begin
				idle <= 0;
				nfall <= 0;
			end else if (idle < 100000) begin
				idle <= idle + 1;
			end
		end
	end

	property p_strobe_one;
		gray_latch_strobe |=> !gray_latch_strobe;
	endproperty
	property p_strobe_idle;
		gray_latch_strobe |-> idle >= IDLE_CYCLES;
	endproperty
	property p_strobe_fall;
		gray_latch_strobe |-> nfall == 2;
	endproperty
	property p_strobe_delay;
		gray_latch_strobe |-> fall_age >= 1 && fall_age <= 4;
	endproperty
	property p_retime;
		$rose(serial_data_out) && idle > IDLE_CYCLES + 2
			|-> serial_data_out [*3] ##1 !serial_data_out;
	endproperty
	property p_quiet;
		!seen && !gray_latch_strobe |-> !frame_active && ch_out == '0;
	endproperty
	property p_frame_on;
		gray_latch_strobe |=> frame_active;
	endproperty
	property p_fast_edge;
		$changed(fast_edge) |-> gray_latch_strobe
			|| $past(gray_latch_strobe) || $past(gray_latch_strobe, 2);
	endproperty
	property p_ch_in_frame;
		$changed(ch_out) |-> frame_active || $past(frame_active)
			|| $past(frame_active, 2);
	endproperty

	a_strobe_one: assert property (p_strobe_one)
		else $error("latch strobe wider than one cycle");
	a_strobe_idle: assert property (p_strobe_idle)
		else $error("latch without a long enough idle gap");
	a_strobe_fall: assert property (p_strobe_fall)
		else $error("latch not on the second data fall");
	a_strobe_delay: assert property (p_strobe_delay)
		else $error("latch strobe late after the data fall");
	a_retime: assert property (p_retime)
		else $error("forwarded pulse not three cycles wide");
	a_quiet: assert property (p_quiet)
		else $error("outputs active before the first latch");
	a_frame_on: assert property (p_frame_on)
		else $error("no frame running after a latch");
	a_fast_edge: assert property (p_fast_edge)
		else $error("edge speed changed away from a latch");
	a_ch_in_frame: assert property (p_ch_in_frame)
		else $error("channel output moved with no frame");

	c_latch: cover property (gray_latch_strobe);
	c_frame_end: cover property ($fell(frame_active));
	c_retime: cover property ($rose(serial_data_out) && idle > IDLE_CYCLES);
endmodule

bind rgbp_core rgbp_core_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
	.ref_clk, .rst, .serial_data_in, .serial_clock_in, .ext_gray_clock_pin,
	.serial_data_out, .serial_clock_out, .ch_out, .fast_edge,
	.gray_latch_strobe, .frame_active
);
`default_nettype wire

/* rgbp_fifo.sv */
// Purpose: Word FIFO between the serial deserialiser and the frame stage.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/1ps
`default_nettype none
module rgbp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* rgbp_host_model.sv */
// Purpose: Host side of the serial link plus the external gray clock.
// Assumes: Tasks are entered just after a rising ref_clk edge.
// Notes: Link clock stands still between frames; data is held low.
`timescale 1ns/1ps
`default_nettype none
module rgbp_host_model (
	// Clock
	input wire logic ref_clk,
	// Link to the device
	output logic serial_data_in,
	output logic serial_clock_in,
	output logic ext_gray_clock_pin
);
	initial begin
		serial_data_in = 1'b0;
		serial_clock_in = 1'b0;
		ext_gray_clock_pin = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// command first, then right-aligned channel words
	task automatic send_frame(input logic [15:0] cmd, input logic [15:0] v [12]);
		logic [15:0] w;
		for (int i = -1; i < 12; i++) begin
			w = (i < 0) ? cmd : v[i];
			for (int b = 15; b >= 0; b--) begin
				serial_data_in <= w[b];
				serial_clock_in <= 1'b0;
				wait_cyc(2);
				serial_clock_in <= 1'b1;
				wait_cyc(2);
			end
		end
		serial_data_in <= 1'b0;
		serial_clock_in <= 1'b0;
	endtask

	// idle gap, then four 100 ns pulses with 250 ns gaps
	task automatic latch(input int idle);
		wait_cyc(idle);
		repeat (4) begin
			serial_data_in <= 1'b1;
			wait_cyc(4);
			serial_data_in <= 1'b0;
			wait_cyc(10);
		end
	endtask

	// Four cycles let edge detect, counter and output register settle.
	task automatic tick();
		ext_gray_clock_pin <= ~ext_gray_clock_pin;
		wait_cyc(4);
	endtask
endmodule
`default_nettype wire

/* rgbp_pkg.sv */
// Purpose: Shared constants and types for the grayscale PWM driver core.
// Assumes: 40 MHz reference clock stands in for the internal oscillator.
// Notes: Frame offsets and timing counts live here; the fall_cnt and div_cnt widths are set in the core.
package rgbp_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int IDLE_US = 220;
	// Least time, so the count rounds up.
	localparam int IDLE_CYC = (IDLE_US * CLK_MHZ * 1000 + 999) / 1000;
	localparam int RETIME_NS = 90;
	// Regenerated pulse width, rounded down, never below one cycle.
	localparam int RETIME_RAW = (RETIME_NS * CLK_MHZ) / 1000;
	localparam int RETIME_CYC = (RETIME_RAW < 1) ? 1 : RETIME_RAW;
	localparam int IDLE_CNT_W = 16;
	localparam int RT_CNT_W = 4;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int GS_W = 16;
	localparam int NCH = 12;
	localparam int NWORD = 13;
	localparam int CMD_IDX = 12;
	localparam int BIT_CNT_W = 4;
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam int FIFO_DEPTH = 16;

	// ----------------------------------------
	// Latch sequence
	// ----------------------------------------
	localparam logic [2:0] LATCH_FALL = 3'h2;
	localparam logic [2:0] SEQ_PULSES = 3'h4;

	// ----------------------------------------
	// Modulation
	// ----------------------------------------
	localparam logic [4:0] DEPTH_8 = 5'h08;
	localparam logic [4:0] DEPTH_12 = 5'h0c;
	localparam logic [4:0] DEPTH_14 = 5'h0e;
	localparam logic [4:0] DEPTH_16 = 5'h10;
	localparam logic [4:0] SEG_FINE = 5'h04;
	localparam logic [4:0] SEG_COARSE = 5'h02;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	typedef struct packed {
		logic [4:0] unused;
		logic fast_edge;
		logic [1:0] grayscale_depth_sel;
		logic [2:0] osc_div;
		logic adaptive_density_modulation;
		logic ext_clk;
		logic polarity;
		logic restart;
		logic one_shot;
	} rgbp_cmd_t;

	typedef enum logic [1:0] {
		ST_SHIFT,
		ST_ARMED,
		ST_DONE
	} rgbp_link_st_t;

	// Oscillator divide ratio as a power of two.
	function automatic logic [3:0] div_log2(input logic [2:0] code);
		logic [3:0] r;
		r = {1'b0, code};
		if (code > 3'h4) begin
			r = {1'b0, code} + 4'h1;
		end
		return r;
	endfunction

	function automatic logic [4:0] depth_bits(input logic [1:0] sel);
		logic [4:0] r;
		unique case (sel)
			2'h0: r = DEPTH_8;
			2'h1: r = DEPTH_12;
			2'h2: r = DEPTH_14;
			2'h3: r = DEPTH_16;
		endcase
		return r;
	endfunction

endpackage

/* tb.sv */
// Purpose: Self-checking bench for the grayscale PWM core and its FIFO.
// Assumes: Short idle count of 50 cycles keeps the run brief.
// Notes: Channel states come from a tick-by-tick model of the counter.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk;
	logic rst;
	logic serial_data_in;
	logic serial_clock_in;
	logic ext_gray_clock_pin;
	logic serial_data_out;
	logic serial_clock_out;
	logic [rgbp_pkg::NCH-1:0] ch_out;
	logic fast_edge;
	logic gray_latch_strobe;
	logic frame_active;
	logic sck_d;
	logic [15:0] vals [12];
	logic [15:0] cur [12];
	int n_mismatch, compares, n_strobe, n_sdo_hi, gcnt, w, hi [12];
	int dw [4] = '{8, 12, 14, 16};
	integer seed;

	rgbp_core #(.IDLE_CYCLES(50)) DUT (.ref_clk, .rst, .serial_data_in,
		.serial_clock_in, .ext_gray_clock_pin, .serial_data_out,
		.serial_clock_out, .ch_out, .fast_edge, .gray_latch_strobe,
		.frame_active);
	rgbp_host_model u_host (.ref_clk, .serial_data_in, .serial_clock_in,
		.ext_gray_clock_pin);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Outputs are sampled mid-cycle, away from the edge that launches them.
	always @(negedge ref_clk) begin
		if (gray_latch_strobe === 1'b1) n_strobe++;
		if (serial_data_out === 1'b1) n_sdo_hi++;
		if (!rst) begin
			check("sck_fwd", sck_d, serial_clock_out);
		end
	end

	always @(posedge ref_clk) begin
		sck_d <= serial_clock_in;
	end

	task automatic check(input string nm, input logic [15:0] exp,
		input logic [15:0] seen);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [11:0] model_on(input int k, input int d);
		logic [11:0] r;
		for (int i = 0; i < 12; i++) begin
			r[i] = cur[i] > (k % (1 << d));
		end
		return r;
	endfunction

	// Extremes in the first two channels, the rest random within depth.
	task automatic load(input logic [15:0] cmd, input int d);
		int s, s2;
		s = n_strobe;
		for (int i = 0; i < 12; i++) begin
			vals[i] = $random(seed) & ((1 << d) - 1);
		end
		vals[0] = (1 << d) - 1;
		vals[1] = 16'h0000;
		u_host.send_frame(cmd, vals);
		u_host.wait_cyc(2);
		s2 = n_sdo_hi;
		u_host.latch(58);
		check("strobe", s + 1, n_strobe);
		check("retime", 4 * rgbp_pkg::RETIME_CYC, n_sdo_hi - s2);
		check("frame_on", 1, frame_active);
	endtask

	task automatic run(input int cnt, input int d, input logic inv);
		for (int t = 0; t < cnt; t++) begin
			check("ch_out", model_on(gcnt, d) ^ {12{inv}}, ch_out);
			u_host.tick();
			gcnt++;
		end
	endtask

	initial begin
		seed = 32'he077d32d;
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check("frame_active", 0, frame_active);
		check("ch_reset", 0, ch_out);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			vals[i] = 16'($random(seed));
		end
		u_host.send_frame(16'h000a, vals);
		u_host.latch(1);
		check("refused_latch", 0, n_strobe);
		check("refused_frame", 0, frame_active);
		$display("test short idle done");
		for (int d = 0; d < 4; d++) begin
			load({5'h00, d[0], d[1:0], 8'h0a}, dw[d]);
			check("fast_edge", d[0], fast_edge);
			cur = vals;
			gcnt = 0;
			run(300, dw[d], 1'b0);
		end
		$display("test depth and restart done");
		load(16'h000f, 8);
		cur = vals;
		gcnt = 0;
		run(256, 8, 1'b1);
		check("oneshot_frame", 0, frame_active);
		u_host.tick();
		check("oneshot_off", 16'h0fff, ch_out);
		$display("test one-shot done");
		load(16'h0008, 8);
		cur = vals;
		gcnt = 0;
		run(100, 8, 1'b0);
		load(16'h0008, 8);
		run(156, 8, 1'b0);
		cur = vals;
		run(50, 8, 1'b0);
		$display("test free-running done");
		for (int c = 0; c < 6; c++) begin
			load({8'h00, c[2:0], c[0], 4'h0}, 8);
			w = 256 << ((c == 5) ? 6 : c);
			hi = '{default: 0};
			repeat (w + 300) @(posedge ref_clk);
			repeat (w) begin
				@(negedge ref_clk);
				for (int i = 0; i < 12; i++) hi[i] += ch_out[i];
			end
			for (int i = 0; i < 12; i++) begin
				check("duty", vals[i] * (w / 256), hi[i]);
			end
		end
		$display("test internal clock done");
		complete_run();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
